// ---- tbpg_defs.svh ----
`ifndef TBPG_DEFS_SVH
`define TBPG_DEFS_SVH

// Register indices; byte address is four times the index
`define TBPG_IDX_FLAGS1   8'h0C
`define TBPG_IDX_FLAGS2   8'h0D
`define TBPG_IDX_TCOUNT   8'h11
`define TBPG_IDX_TCTRL    8'h12
`define TBPG_IDX_DUTY1    8'h15
`define TBPG_IDX_SLAVE1   8'h16
`define TBPG_IDX_CTRL1    8'h17
`define TBPG_IDX_DUTY2    8'h1B
`define TBPG_IDX_SLAVE2   8'h1C
`define TBPG_IDX_CTRL2    8'h1D
`define TBPG_IDX_PORTDIR  8'h87
`define TBPG_IDX_ENABLES1 8'h8C
`define TBPG_IDX_ENABLES2 8'h8D
`define TBPG_IDX_PLIMIT   8'h92

// Reset values
`define TBPG_RST_BYTE     8'h00
`define TBPG_RST_PLIMIT   8'hFF
`define TBPG_RST_PORTDIR  8'hFF

// Field positions
`define TBPG_TCTRL_PS_LSB   0
`define TBPG_TCTRL_ON_BIT   2
`define TBPG_TCTRL_POST_LSB 3
`define TBPG_CTRL_MODE_LSB  0
`define TBPG_CTRL_DLSB_LSB  4
`define TBPG_FLAGS1_MATCH   1
`define TBPG_DIR_BIT_CH1    2
`define TBPG_DIR_BIT_CH2    1

// Timing
`define TBPG_CLK_PERIOD_NS  4
`define TBPG_OSC_PERIOD_NS  4
`define TBPG_OSC_PER_TICK   4
`define TBPG_CLK_PER_OSC    ((`TBPG_OSC_PERIOD_NS + `TBPG_CLK_PERIOD_NS - 1) / `TBPG_CLK_PERIOD_NS)

`endif

// ---- tbpg_pkg.sv ----
package tbpg_pkg;

    typedef enum logic [1:0] {
        TBPG_MODE_OFF,
        TBPG_MODE_OTHER,
        TBPG_MODE_PWM
    } tbpg_mode_type;

    typedef enum logic [1:0] {
        TBPG_PS_1,
        TBPG_PS_4,
        TBPG_PS_16
    } tbpg_prescale_type;

    function automatic tbpg_mode_type tbpg_decode_mode(input logic [3:0] sel);
        if (sel == 4'h0) begin
            return TBPG_MODE_OFF;
        end else if (sel[3:2] == 2'b11) begin
            return TBPG_MODE_PWM;
        end else begin
            return TBPG_MODE_OTHER;
        end
    endfunction : tbpg_decode_mode

    function automatic tbpg_prescale_type tbpg_decode_ps(input logic [1:0] sel);
        case (sel)
            2'b00:   return TBPG_PS_1;
            2'b01:   return TBPG_PS_4;
            default: return TBPG_PS_16;
        endcase
    endfunction : tbpg_decode_ps

endpackage : tbpg_pkg

// ---- tbpg_pwm.sv ----
// The APB slave port was decided locally.
`timescale 1ns/1ns
`include "tbpg_defs.svh"
// Contract
// - Period is (period_limit+1) x 4 oscillator periods x prescale factor.
// - Timer equal to period_limit clears on the next increment, new period.
// - Pin goes high at each period start unless duty is zero.
// - At each period boundary the duty byte and LSBs copy to the slave.
// - Duty is 10 bits: duty byte high, control bits 5:4 low.
// - Duty writes accepted anytime, applied only at the next boundary.
// - In PWM mode the duty slave register ignores software writes.
// - Active duty is held in slave plus 2-bit latch, double buffered.
// - Pin falls when active duty equals timer with two fine bits appended.
// - Duty beyond the period never clears the pin; output stays high.
// - Postscaler only paces the period match flag, never the period.
// - Resolution is log2 of four times (period_limit+1), ten bits max.
// - Mode field 11xx selects PWM; 0000 switches the channel off and resets.
// - Clearing the channel control forces the output latch low.
// - All channels in PWM mode share one period timer.

module tbpg_pwm
    import tbpg_pkg::*;
#(
    parameter int CH_COUNT = 2
) (
    input  wire logic                i_core_clk, // Core clock, one oscillator period
    input  wire logic                i_resetn,   // Synchronous reset, active low
    input  wire logic                i_psel,     // APB select
    input  wire logic                i_penable,  // APB enable
    input  wire logic                i_pwrite,   // APB direction, high for write
    input  wire logic [11:0]         i_paddr,    // APB byte address
    input  wire logic [31:0]         i_pwdata,   // APB write data
    output logic                     o_pready,   // APB ready
    output logic [31:0]              o_prdata,   // APB read data
    output logic                     o_pslverr,  // APB error, unmapped address
    output logic [CH_COUNT-1:0]      o_pwm_out,  // PWM output pins
    output logic [CH_COUNT-1:0]      o_pwm_oe    // Pin output enables
);

    if (CH_COUNT < 1 || CH_COUNT > 2) begin : g_bad_ch
        $error("CH_COUNT must be 1 or 2");
    end
    if (`TBPG_CLK_PER_OSC != 1) begin : g_bad_clk
        $error("Core clock must equal the oscillator period");
    end

    localparam logic [7:0] DUTY_IDX [2]  = '{`TBPG_IDX_DUTY1, `TBPG_IDX_DUTY2};
    localparam logic [7:0] SLAVE_IDX [2] = '{`TBPG_IDX_SLAVE1, `TBPG_IDX_SLAVE2};
    localparam logic [7:0] CTRL_IDX [2]  = '{`TBPG_IDX_CTRL1, `TBPG_IDX_CTRL2};
    localparam int         DIR_BIT [2]   = '{`TBPG_DIR_BIT_CH1, `TBPG_DIR_BIT_CH2};
    localparam logic [1:0] QMAX          = 2'(`TBPG_OSC_PER_TICK - 1);

    logic [7:0]  reg_idx;
    logic [7:0]  wbyte;
    logic        setup;
    logic        wr_en;
    logic [7:0]  rd_val;
    logic        rd_hit;

    logic [7:0]  flags1_r;
    logic        flags2_r;
    logic [7:0]  enables1_r;
    logic        enables2_r;
    logic [7:0]  portdir_r;
    logic [7:0]  plimit_r;
    logic [7:0]  tcount_r;
    logic [6:0]  tctrl_r;
    logic [1:0]  q_r;
    logic [3:0]  pre_r;
    logic [3:0]  post_r;

    logic [7:0]  duty_byte_r [CH_COUNT];
    logic [7:0]  slave_r [CH_COUNT];
    logic [5:0]  ctrl_r [CH_COUNT];
    logic [1:0]  lsb_r [CH_COUNT];

    tbpg_prescale_type ps;
    logic [3:0]  pre_max;
    logic        timer_on;
    logic        tick;
    logic        period_end;
    logic        post_hit;
    logic [1:0]  fine_lo;
    logic        adv;
    logic [9:0]  cmp_val;
    logic [9:0]  cmp_nxt;

    assign reg_idx = i_paddr[9:2];
    assign wbyte   = i_pwdata[7:0];
    assign setup   = i_psel & ~i_penable;
    // Writes land only at the completing edge of the access phase
    assign wr_en   = i_psel & i_penable & o_pready & i_pwrite;

    // APB read mux
    always_comb begin
        rd_val = 8'h00;
        rd_hit = 1'b1;
        case (reg_idx)
            `TBPG_IDX_FLAGS1:   rd_val = flags1_r;
            `TBPG_IDX_FLAGS2:   rd_val = {7'h00, flags2_r};
            `TBPG_IDX_TCOUNT:   rd_val = tcount_r;
            `TBPG_IDX_TCTRL:    rd_val = {1'b0, tctrl_r};
            `TBPG_IDX_PORTDIR:  rd_val = portdir_r;
            `TBPG_IDX_ENABLES1: rd_val = enables1_r;
            `TBPG_IDX_ENABLES2: rd_val = {7'h00, enables2_r};
            `TBPG_IDX_PLIMIT:   rd_val = plimit_r;
            default:            rd_hit = 1'b0;
        endcase
        for (int c = 0; c < CH_COUNT; c++) begin
            if (reg_idx == DUTY_IDX[c]) begin
                rd_val = duty_byte_r[c];
                rd_hit = 1'b1;
            end
            if (reg_idx == SLAVE_IDX[c]) begin
                rd_val = slave_r[c];
                rd_hit = 1'b1;
            end
            if (reg_idx == CTRL_IDX[c]) begin
                rd_val = {2'b00, ctrl_r[c]};
                rd_hit = 1'b1;
            end
        end
    end

    // No wait states: data is sampled in setup, so ready is always one cycle later
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (setup) begin
            o_pready  <= 1'b1;
            o_prdata  <= {24'h00_0000, rd_val};
            o_pslverr <= ~rd_hit;
        end else begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end
    end

    // Plain configuration registers
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            enables1_r <= `TBPG_RST_BYTE;
            enables2_r <= 1'b0;
            portdir_r  <= `TBPG_RST_PORTDIR;
            plimit_r   <= `TBPG_RST_PLIMIT;
            tctrl_r    <= 7'(`TBPG_RST_BYTE);
            flags2_r   <= 1'b0;
        end else if (wr_en) begin
            case (reg_idx)
                `TBPG_IDX_ENABLES1: enables1_r <= wbyte;
                `TBPG_IDX_ENABLES2: enables2_r <= wbyte[0];
                `TBPG_IDX_PORTDIR:  portdir_r  <= wbyte;
                `TBPG_IDX_PLIMIT:   plimit_r   <= wbyte;
                `TBPG_IDX_TCTRL:    tctrl_r    <= wbyte[6:0];
                `TBPG_IDX_FLAGS2:   flags2_r   <= wbyte[0];
                default: ;
            endcase
        end
    end

    // Shared time base
    assign ps       = tbpg_decode_ps(tctrl_r[`TBPG_TCTRL_PS_LSB +: 2]);
    assign timer_on = tctrl_r[`TBPG_TCTRL_ON_BIT];

    always_comb begin
        case (ps)
            TBPG_PS_1: begin
                pre_max = 4'h0;
                fine_lo = q_r;
                adv     = 1'b1;
            end
            TBPG_PS_4: begin
                pre_max = 4'h3;
                fine_lo = pre_r[1:0];
                adv     = timer_on & (q_r == QMAX);
            end
            default: begin
                pre_max = 4'hF;
                fine_lo = pre_r[3:2];
                adv     = timer_on & (q_r == QMAX) & (pre_r[1:0] == 2'b11);
            end
        endcase
    end

    assign tick       = timer_on & (q_r == QMAX) & (pre_r == pre_max);
    assign period_end = tick & (tcount_r == plimit_r);
    assign cmp_val    = {tcount_r, fine_lo};
    // Registered pin falls at the edge that starts the matching count
    assign cmp_nxt    = cmp_val + {9'h000, adv};

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            q_r <= 2'b00;
        end else begin
            q_r <= q_r + 2'b01;
        end
    end

    // Prescaler restarts on any timer write; q_r keeps running, so the first tick can be up to 3 cycles short
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            pre_r <= 4'h0;
        end else if (wr_en && (reg_idx == `TBPG_IDX_TCOUNT || reg_idx == `TBPG_IDX_TCTRL)) begin
            pre_r <= 4'h0;
        end else if (!timer_on) begin
            pre_r <= 4'h0;
        end else if (q_r == QMAX) begin
            pre_r <= (pre_r == pre_max) ? 4'h0 : pre_r + 4'h1;
        end
    end

    // Software write beats the increment in the same cycle
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            tcount_r <= `TBPG_RST_BYTE;
        end else if (wr_en && reg_idx == `TBPG_IDX_TCOUNT) begin
            tcount_r <= wbyte;
        end else if (period_end) begin
            tcount_r <= 8'h00;
        end else if (tick) begin
            tcount_r <= tcount_r + 8'h01;
        end
    end

    // Postscaler counts periods for the flag only
    assign post_hit = period_end & (post_r == tctrl_r[`TBPG_TCTRL_POST_LSB +: 4]);

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            post_r <= 4'h0;
        end else if (wr_en && reg_idx == `TBPG_IDX_TCTRL) begin
            post_r <= 4'h0;
        end else if (period_end) begin
            post_r <= post_hit ? 4'h0 : post_r + 4'h1;
        end
    end

    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            flags1_r <= `TBPG_RST_BYTE;
        end else begin
            flags1_r <= ((wr_en && reg_idx == `TBPG_IDX_FLAGS1) ? wbyte : flags1_r)
                      | (8'(post_hit) << `TBPG_FLAGS1_MATCH);
        end
    end

    // Channels
    for (genvar c = 0; c < CH_COUNT; c++) begin : g_ch
        tbpg_mode_type mode;
        logic [9:0]    duty_new;
        logic [9:0]    duty_act;

        assign mode     = tbpg_decode_mode(ctrl_r[c][`TBPG_CTRL_MODE_LSB +: 4]);
        assign duty_new = {duty_byte_r[c], ctrl_r[c][`TBPG_CTRL_DLSB_LSB +: 2]};
        assign duty_act = {slave_r[c], lsb_r[c]};

        always_ff @(posedge i_core_clk) begin
            if (!i_resetn) begin
                duty_byte_r[c] <= `TBPG_RST_BYTE;
                ctrl_r[c]      <= 6'(`TBPG_RST_BYTE);
            end else if (wr_en && reg_idx == DUTY_IDX[c]) begin
                duty_byte_r[c] <= wbyte;
            end else if (wr_en && reg_idx == CTRL_IDX[c]) begin
                ctrl_r[c]      <= wbyte[5:0];
            end
        end

        // In PWM mode active duty changes only at a boundary, so the pin never glitches
        always_ff @(posedge i_core_clk) begin
            if (!i_resetn) begin
                slave_r[c] <= `TBPG_RST_BYTE;
                lsb_r[c]   <= 2'b00;
            end else begin
                case (mode)
                    TBPG_MODE_OFF: begin
                        slave_r[c] <= 8'h00;
                        lsb_r[c]   <= 2'b00;
                    end
                    TBPG_MODE_PWM: begin
                        if (period_end) begin
                            slave_r[c] <= duty_byte_r[c];
                            lsb_r[c]   <= ctrl_r[c][`TBPG_CTRL_DLSB_LSB +: 2];
                        end
                    end
                    default: begin
                        if (wr_en && reg_idx == SLAVE_IDX[c]) begin
                            slave_r[c] <= wbyte;
                        end
                    end
                endcase
            end
        end

        always_ff @(posedge i_core_clk) begin
            if (!i_resetn) begin
                o_pwm_out[c] <= 1'b0;
            end else if (mode != TBPG_MODE_PWM) begin
                o_pwm_out[c] <= 1'b0;
            end else if (period_end) begin
                o_pwm_out[c] <= (duty_new != 10'h000);
            end else if (duty_act == cmp_nxt) begin
                // No match exists when duty exceeds the period
                o_pwm_out[c] <= 1'b0;
            end
        end

        always_ff @(posedge i_core_clk) begin
            if (!i_resetn) begin
                o_pwm_oe[c] <= 1'b0;
            end else begin
                o_pwm_oe[c] <= ~portdir_r[DIR_BIT[c]];
            end
        end
    end

endmodule : tbpg_pwm

// ---- tbpg_load.sv ----
`timescale 1ns/1ns
module tbpg_load (
    input  wire logic        i_clk,    // Core clock
    input  wire logic        i_pin,    // Pin level from the channel
    input  wire logic        i_oe,     // Pin driven by the channel
    output logic [15:0]      o_period, // Cycles between the last two rises
    output logic [15:0]      o_high    // High cycles in the last full period
);
    logic [15:0] cnt_r = 16'h0000;
    logic [15:0] hi_r = 16'h0000;
    logic [15:0] per_r = 16'h0000;
    logic [15:0] high_r = 16'h0000;
    logic        prev_r = 1'b0;
    logic        lvl;

    // The load pulls an undriven pin low, so a released pin never reads high
    assign lvl = i_oe & i_pin;
    assign o_period = per_r;
    assign o_high = high_r;

    always @(posedge i_clk) begin
        prev_r <= lvl;
        if (lvl && !prev_r) begin
            per_r <= cnt_r;
            high_r <= hi_r;
            cnt_r <= 16'h0001;
            hi_r <= 16'h0001;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
            hi_r <= hi_r + {15'h0000, lvl};
        end
    end
endmodule : tbpg_load

// ---- tbpg_asserts.sv ----
`timescale 1ns/1ns
`include "tbpg_defs.svh"
module tbpg_asserts #(
    parameter int CH_COUNT = 2
) (
    input wire logic                i_core_clk, // Core clock
    input wire logic                i_resetn,   // Reset, active low
    input wire logic                i_psel,     // APB select
    input wire logic                i_penable,  // APB enable
    input wire logic                i_pwrite,   // APB direction
    input wire logic [11:0]         i_paddr,    // APB address
    input wire logic [31:0]         i_pwdata,   // APB write data
    input wire logic                o_pready,   // APB ready
    input wire logic [31:0]         o_prdata,   // APB read data
    input wire logic                o_pslverr,  // APB error
    input wire logic [CH_COUNT-1:0] o_pwm_out,  // PWM pins
    input wire logic [CH_COUNT-1:0] o_pwm_oe    // Pin enables
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    logic [7:0] idx;
    logic       mapped;
    assign idx = i_paddr[9:2];
    assign mapped = idx inside {`TBPG_IDX_FLAGS1, `TBPG_IDX_FLAGS2, `TBPG_IDX_TCOUNT,
        `TBPG_IDX_TCTRL, `TBPG_IDX_DUTY1, `TBPG_IDX_SLAVE1, `TBPG_IDX_CTRL1,
        `TBPG_IDX_DUTY2, `TBPG_IDX_SLAVE2, `TBPG_IDX_CTRL2, `TBPG_IDX_PORTDIR,
        `TBPG_IDX_ENABLES1, `TBPG_IDX_ENABLES2, `TBPG_IDX_PLIMIT};

    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_access;
        i_psel && i_penable;
    endsequence
    sequence s_off(logic [7:0] r);
        s_access ##0 (o_pready && i_pwrite && idx == r && i_pwdata[3:0] == 4'h0);
    endsequence

    AST_READY_ONE: assert property (s_setup ##1 s_access |-> o_pready)
        else $error("ready missing in access cycle");
    AST_READY_PULSE: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    AST_ERR_QUAL: assert property (o_pslverr |-> o_pready && i_psel && i_penable)
        else $error("error outside an access cycle");
    AST_UNMAPPED: assert property (s_setup ##0 !mapped ##1 s_access |-> o_pslverr)
        else $error("unmapped access without error");
    AST_MAPPED: assert property (s_setup ##0 mapped ##1 s_access |-> !o_pslverr)
        else $error("mapped access with error");
    AST_UPPER_ZERO: assert property (o_pready |-> o_prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    AST_CH1_OFF: assert property (s_off(`TBPG_IDX_CTRL1) |-> ##2 (!o_pwm_out[0]) [*3])
        else $error("channel one pin high after switch off");
    AST_CH2_OFF: assert property (s_off(`TBPG_IDX_CTRL2) |-> ##2 (!o_pwm_out[1]) [*3])
        else $error("channel two pin high after switch off");
    AST_OE_RESET: assert property ($rose(i_resetn) |-> o_pwm_oe == '0 && o_pwm_out == '0)
        else $error("pins active right after reset");
endmodule : tbpg_asserts

bind tbpg_pwm tbpg_asserts #(.CH_COUNT(CH_COUNT)) tbpg_asserts_inst (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .o_pwm_out(o_pwm_out), .o_pwm_oe(o_pwm_oe)
);

// ---- testbench.sv ----
`timescale 1ns/1ns
`include "tbpg_defs.svh"
module testbench;
    logic            clk = 1'b0;
    logic            resetn = 1'b0;
    logic            psel = 1'b0;
    logic            penable = 1'b0;
    logic            pwrite = 1'b0;
    logic [11:0]     paddr = 12'h000;
    logic [31:0]     pwdata = 32'h0000_0000;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
    logic [1:0]      pwm;
    logic [1:0]      oe;
    logic [1:0][15:0] per;
    logic [1:0][15:0] hi;
    logic [7:0]      rd;
    logic            err;
    int              error_cnt = 0;
    int              checks_done = 0;
    int              cyc = 0;
    int              f;
    int              n;
    logic [7:0]      ri[6] = '{`TBPG_IDX_PLIMIT, `TBPG_IDX_PORTDIR, `TBPG_IDX_TCTRL,
                               `TBPG_IDX_TCOUNT, `TBPG_IDX_CTRL1, `TBPG_IDX_DUTY1};
    logic [7:0]      rv[6] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};

    initial begin
        forever #2 clk = ~clk;
    end

    tbpg_pwm #(.CH_COUNT(2)) tbpg_pwm_inst (
        .i_core_clk(clk), .i_resetn(resetn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .o_pwm_out(pwm), .o_pwm_oe(oe)
    );
    tbpg_load tbpg_load_inst[1:0] (
        .i_clk(clk), .i_pin(pwm), .i_oe(oe), .o_period(per), .o_high(hi)
    );

    task automatic stop_test;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Request is held until the edge that samples ready high
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            error_cnt++;
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        chk(nm, {8'h00, e}, {8'h00, rd});
    endtask : rdchk

    // Counts cycles in which channel one is not at the given level
    task automatic off_level(input logic lv);
        n = 0;
        repeat (64) begin
            @(posedge clk);
            n += int'(pwm[0] !== lv);
        end
    endtask : off_level

    task automatic rise;
        int k;
        k = 0;
        while (pwm[0] !== 1'b0 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        while (pwm[0] !== 1'b1 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 2000) begin
            error_cnt++;
        end
    endtask : rise

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rdchk("reset value", ri[i], rv[i]);
        end
        apb(1'b0, 8'h00, 8'h00);
        chk("unmapped error", 16'h0001, {15'h0000, err});
        apb(1'b1, `TBPG_IDX_PLIMIT, 8'h03);
        apb(1'b1, `TBPG_IDX_DUTY1, 8'h02);
        apb(1'b1, `TBPG_IDX_CTRL1, 8'h10);
        apb(1'b1, `TBPG_IDX_DUTY2, 8'h01);
        apb(1'b1, `TBPG_IDX_PORTDIR, 8'hF9);
        // Enables follow the direction register one cycle late
        repeat (2) @(posedge clk);
        chk("pin enables", 16'h0003, {14'h0000, oe});
        // Postscale at maximum must leave the period alone
        for (int p = 0; p < 4; p++) begin
            f = (p == 0) ? 1 : (p == 1) ? 4 : 16;
            apb(1'b1, `TBPG_IDX_TCTRL, 8'h7C | 8'(p));
            apb(1'b1, `TBPG_IDX_CTRL1, 8'h1C | 8'(p));
            apb(1'b1, `TBPG_IDX_CTRL2, 8'h0C | 8'(p));
            repeat (64 * f) @(posedge clk);
            chk("period ch1", 16'(16 * f), per[0]);
            chk("high ch1", 16'(9 * f), hi[0]);
            chk("period ch2", 16'(16 * f), per[1]);
            chk("high ch2", 16'(4 * f), hi[1]);
        end
        rise();
        apb(1'b1, `TBPG_IDX_DUTY1, 8'h03);
        rdchk("slave held", `TBPG_IDX_SLAVE1, 8'h02);
        repeat (600) @(posedge clk);
        rdchk("slave loaded", `TBPG_IDX_SLAVE1, 8'h03);
        chk("new high", 16'd208, hi[0]);
        apb(1'b1, `TBPG_IDX_SLAVE1, 8'hAA);
        rdchk("slave read only", `TBPG_IDX_SLAVE1, 8'h03);
        apb(1'b1, `TBPG_IDX_TCTRL, 8'h04);
        apb(1'b1, `TBPG_IDX_DUTY1, 8'hFF);
        repeat (64) @(posedge clk);
        off_level(1'b1);
        chk("duty over period", 16'h0000, 16'(n));
        rdchk("match flag", `TBPG_IDX_FLAGS1, 8'h02);
        apb(1'b1, `TBPG_IDX_DUTY1, 8'h00);
        apb(1'b1, `TBPG_IDX_CTRL1, 8'h0C);
        repeat (64) @(posedge clk);
        off_level(1'b0);
        chk("zero duty", 16'h0000, 16'(n));
        apb(1'b1, `TBPG_IDX_DUTY1, 8'h02);
        apb(1'b1, `TBPG_IDX_CTRL1, 8'h1C);
        repeat (64) @(posedge clk);
        apb(1'b1, `TBPG_IDX_CTRL1, 8'h00);
        apb(1'b1, `TBPG_IDX_CTRL2, 8'h00);
        off_level(1'b0);
        chk("off pin low", 16'h0000, 16'(n));
        rdchk("off slave", `TBPG_IDX_SLAVE1, 8'h00);
        stop_test();
    end
endmodule : testbench
